// ---- design/nvbp_host.sv ----
`default_nettype none
module nvbp_host (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // user request
  input wire logic req_valid_i,
  input wire logic req_write_i,
  input wire logic [nvbp_pkg::ADDR_W-1:0] req_addr_i,
  input wire logic [nvbp_pkg::DATA_W-1:0] req_wdata_i,
  input wire logic supply_ok_i,
  output logic req_ready_o,
  // user answer
  output logic rsp_valid_o,
  output logic [nvbp_pkg::DATA_W-1:0] rsp_rdata_o,
  // decoded address of the cycle in flight
  output logic [nvbp_pkg::BLK_W-1:0] block_select_bits_o,
  output logic [nvbp_pkg::COL_W-1:0] column_select_bits_o,
  output logic [nvbp_pkg::ROW_W-1:0] row_select_bits_o,
  // memory pins
  output logic mem_addr_o_unused_guard_o,
  output logic [nvbp_pkg::ADDR_W-1:0] mem_addr_o,
  output logic chip_sel_n_o,
  output logic write_n_o,
  output logic out_en_n_o,
  input wire logic [nvbp_pkg::DATA_W-1:0] byte_data_lines_i,
  output logic [nvbp_pkg::DATA_W-1:0] byte_data_lines_o,
  output logic byte_data_lines_oe_o
);
  // ----------------------------------------------------------------
  // state and registers
  // ----------------------------------------------------------------
  nvbp_pkg::nvbp_state_t state;
  nvbp_pkg::nvbp_state_t next_state;
  logic is_write;
  logic [nvbp_pkg::ADDR_W-1:0] addr;
  logic [nvbp_pkg::DATA_W-1:0] wdata;
  logic [nvbp_pkg::DATA_W-1:0] din_meta;
  logic [nvbp_pkg::DATA_W-1:0] din_sync;
  logic supply_meta;
  logic supply_sync;
  nvbp_timer_if tmr ();

  nvbp_phase_timer u_timer (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .tmr(tmr)
  );

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  localparam logic [nvbp_pkg::CNT_W-1:0] ACT_END =
    nvbp_pkg::CNT_W'(nvbp_pkg::ACTIVE_MIN_CYC - 1);
  localparam logic [nvbp_pkg::CNT_W-1:0] WR_START =
    nvbp_pkg::CNT_W'(nvbp_pkg::ADDR_HOLD_CYC);
  localparam logic [nvbp_pkg::CNT_W-1:0] PRE_END =
    nvbp_pkg::CNT_W'(nvbp_pkg::PRECHARGE_CYC - 1);
  // reads keep select low one cycle past the access time, so the byte
  // has stood at the pins a full cycle when the input flop takes it
  localparam logic [nvbp_pkg::CNT_W-1:0] RD_END =
    nvbp_pkg::CNT_W'(nvbp_pkg::ACCESS_CYC);
  // the two sync flops hand that byte on one cycle into precharge
  localparam logic [nvbp_pkg::CNT_W-1:0] SAMPLE_AT =
    nvbp_pkg::CNT_W'(1);
  wire logic in_idle = state == nvbp_pkg::NVBP_IDLE;
  wire logic in_act = state == nvbp_pkg::NVBP_ACTIVE;
  wire logic in_pre = state == nvbp_pkg::NVBP_PRECHARGE;
  // accept only in idle with a valid request and a healthy supply
  wire logic take = in_idle && req_valid_i && supply_sync;
  // select low three cycles for a write, four for a read, both far
  // under the maximum active time
  wire logic [nvbp_pkg::CNT_W-1:0] act_end = is_write ? ACT_END : RD_END;
  wire logic act_done = in_act && tmr.elapsed == act_end;
  wire logic pre_done = in_pre && tmr.elapsed == PRE_END;
  // read byte taken from the sync output once it holds the pin value
  // caught at the select rising edge
  wire logic rd_sample = in_pre && !is_write && tmr.elapsed == SAMPLE_AT;

  assign tmr.load = take || act_done;
  assign tmr.value = '0;
  assign req_ready_o = in_idle && supply_sync;

  // next state: every cycle is access then precharge
  always_comb begin
    next_state = state;
    unique case (state)
      nvbp_pkg::NVBP_IDLE: begin
        if (take) next_state = nvbp_pkg::NVBP_ACTIVE;
      end
      nvbp_pkg::NVBP_ACTIVE: begin
        if (act_done) next_state = nvbp_pkg::NVBP_PRECHARGE;
      end
      nvbp_pkg::NVBP_PRECHARGE: begin
        if (pre_done) next_state = nvbp_pkg::NVBP_IDLE;
      end
      default: next_state = nvbp_pkg::NVBP_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // cycle plan, counted from the edge that takes a request
  // ----------------------------------------------------------------
  // write: select and write strobe low for three cycles and rising
  //   together; data driven one cycle longer for hold
  // read: select and output strobe low for four cycles, so the byte
  //   is sampled well after the access time, never at its edge
  // precharge: select high at least two cycles before the next take
  // the answer pulse marks a finished write or a captured read byte
  // trade-off: a read costs one cycle more than a write, bought for
  //   a safe sampling point in front of the two sync flops
  // limitation: the phase timer saturates, so the active time can
  //   never be stretched near its maximum by this sequencer

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state <= nvbp_pkg::NVBP_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // request capture; address held for the whole cycle
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      is_write <= 1'b0;
      addr <= '0;
      wdata <= '0;
    end else if (take) begin
      is_write <= req_write_i;
      addr <= req_addr_i;
      wdata <= req_wdata_i;
    end
  end

  // pin inputs pass two flops before use
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      din_meta <= '0;
      din_sync <= '0;
      supply_meta <= 1'b0;
      supply_sync <= 1'b0;
    end else begin
      din_meta <= byte_data_lines_i;
      din_sync <= din_meta;
      supply_meta <= supply_ok_i;
      supply_sync <= supply_meta;
    end
  end

  // ----------------------------------------------------------------
  // pin drive, all registered
  // ----------------------------------------------------------------
  // select pulses per access, never left low
  wire logic next_cs_n = !(take || (in_act && !act_done));
  // write strobe low at select fall: select-controlled write
  wire logic next_we_n = !((take && req_write_i) ||
                           (in_act && is_write && !act_done));
  // output strobe only for reads; early drive is harmless
  wire logic next_oe_n = !((take && !req_write_i) ||
                           (in_act && !is_write && !act_done));
  // data driven through the write and one hold cycle after
  wire logic next_dq_oe = (take && req_write_i) ||
                          (in_act && is_write);

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      chip_sel_n_o <= 1'b1;
      write_n_o <= 1'b1;
      out_en_n_o <= 1'b1;
      byte_data_lines_oe_o <= 1'b0;
    end else begin
      chip_sel_n_o <= next_cs_n;
      write_n_o <= next_we_n;
      out_en_n_o <= next_oe_n;
      byte_data_lines_oe_o <= next_dq_oe;
    end
  end

  assign mem_addr_o = addr;
  assign byte_data_lines_o = wdata;
  assign mem_addr_o_unused_guard_o = 1'b0;
  // row from the low bits, block from the top
  assign row_select_bits_o = addr[nvbp_pkg::ROW_LSB +: nvbp_pkg::ROW_W];
  assign column_select_bits_o =
    addr[nvbp_pkg::COL_LSB +: nvbp_pkg::COL_W];
  assign block_select_bits_o =
    addr[nvbp_pkg::BLK_LSB +: nvbp_pkg::BLK_W];

  // ----------------------------------------------------------------
  // answer pulse for a write or a read, and the read byte
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      rsp_valid_o <= 1'b0;
      rsp_rdata_o <= '0;
    end else begin
      rsp_valid_o <= rd_sample || (pre_done && is_write);
      if (rd_sample) rsp_rdata_o <= din_sync;
    end
  end
endmodule : nvbp_host
`default_nettype wire

// ---- design/nvbp_pkg.sv ----
`default_nettype none
package nvbp_pkg;
  // ----------------------------------------------------------------
  // address layout
  // ----------------------------------------------------------------
  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;
  localparam int ROW_LSB = 0;
  localparam int ROW_W = 8;
  localparam int COL_LSB = 8;
  localparam int COL_W = 2;
  localparam int BLK_LSB = 10;
  localparam int BLK_W = 3;
  // ----------------------------------------------------------------
  // timing, ns and derived cycles at the system clock
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int ACTIVE_MIN_NS = 120;
  localparam int ACTIVE_MAX_NS = 10000;
  localparam int PRECHARGE_MIN_NS = 60;
  localparam int ACCESS_NS = 120;
  localparam int WRITE_PULSE_NS = 40;
  localparam int ADDR_HOLD_NS = 10;
  // least times round up
  localparam int ACTIVE_MIN_CYC =
    (ACTIVE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PRECHARGE_CYC =
    (PRECHARGE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACCESS_CYC =
    (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_PULSE_CYC =
    (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ADDR_HOLD_CYC =
    (ADDR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // longest time rounds down
  localparam int ACTIVE_MAX_CYC = ACTIVE_MAX_NS / CLK_PERIOD_NS;
  localparam int CNT_W = 4;
  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    NVBP_IDLE = 4'h1,
    NVBP_ACTIVE = 4'h2,
    NVBP_PRECHARGE = 4'h4,
    NVBP_RESERVED = 4'h8
  } nvbp_state_t;
endpackage : nvbp_pkg
`default_nettype wire

// ---- design/nvbp_timer_if.sv ----
`default_nettype none
// ------------------------------------------------------------------
// load, start value and elapsed count of the phase timer
// ------------------------------------------------------------------
interface nvbp_timer_if;
  logic load;
  logic [nvbp_pkg::CNT_W-1:0] value;
  logic [nvbp_pkg::CNT_W-1:0] elapsed;
  modport owner (output load, output value, input elapsed);
  modport timer (input load, input value, output elapsed);
endinterface : nvbp_timer_if
`default_nettype wire

// ---- design/nvbp_phase_timer.sv ----
`default_nettype none
// ------------------------------------------------------------------
// phase timer: counts cycles since the last load
// ------------------------------------------------------------------
module nvbp_phase_timer (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // control
  nvbp_timer_if.timer tmr
);
  logic [nvbp_pkg::CNT_W-1:0] count;
  wire logic at_top = &count;
  // saturate so a long stall cannot wrap the count
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      count <= '0;
    end else if (tmr.load) begin
      count <= tmr.value;
    end else if (!at_top) begin
      count <= count + 4'h1;
    end
  end
  assign tmr.elapsed = count;
endmodule : nvbp_phase_timer
`default_nettype wire

// ---- tb/nvbp_mem_model.sv ----
`default_nettype none
// ----------------------------------------------------------------
// behavioural bytewide nonvolatile memory
// ----------------------------------------------------------------
module nvbp_mem_model #(
  parameter int ACC_NS = 100
) (
  // memory pins
  input wire logic cs_n_i,
  input wire logic we_n_i,
  input wire logic oe_n_i,
  input wire logic [12:0] addr_i,
  input wire logic [7:0] data_i,
  output logic [7:0] data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:8191]; // block, column, row in one index
  logic [12:0] lat = 13'h0000;
  logic wr = 1'b0;
  logic rdy = 1'b0;
  logic oe_d = 1'b1;
  // falling select latches address and write intent
  always @(negedge cs_n_i) begin
    lat = addr_i;
    wr = !we_n_i;
    rdy = 1'b0;
    #(ACC_NS) rdy = !cs_n_i; // data only after the access time
  end
  // a strobe falling inside the cycle still makes it a write
  always @(negedge we_n_i) if (!cs_n_i) wr = 1'b1;
  // first rising strobe ends the write, no busy time follows
  always @(posedge cs_n_i or posedge we_n_i) begin
    if (wr) mem[lat] = data_i;
    wr = 1'b0;
  end
  // precharge starts only at select rising; short output hold
  always @(posedge cs_n_i) rdy <= #10 1'b0;
  always @(oe_n_i) oe_d <= #10 oe_n_i;
  // released bus shows the inverse, not a stale byte
  // no supply monitor: access is never refused
  assign data_o = (rdy && !wr && !oe_d) ? mem[lat] : ~mem[lat];
endmodule : nvbp_mem_model
`default_nettype wire

// ---- tb/nvbp_host_chk.sv ----
`default_nettype none
// ----------------------------------------------------------------
// port checker for the bytewide host
// ----------------------------------------------------------------
module nvbp_host_chk (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // user side
  input wire logic req_valid_i,
  input wire logic req_write_i,
  input wire logic supply_ok_i,
  input wire logic req_ready_o,
  input wire logic rsp_valid_o,
  // memory side
  input wire logic [nvbp_pkg::ADDR_W-1:0] mem_addr_o,
  input wire logic [nvbp_pkg::BLK_W-1:0] block_select_bits_o,
  input wire logic chip_sel_n_o,
  input wire logic write_n_o,
  input wire logic out_en_n_o,
  input wire logic byte_data_lines_oe_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  sequence s_rd; req_valid_i && req_ready_o && !req_write_i; endsequence
  sequence s_wr; req_valid_i && req_ready_o && req_write_i; endsequence
  sequence s_rd_hold;
    (!chip_sel_n_o && !out_en_n_o && write_n_o && !byte_data_lines_oe_o)
      [*4];
  endsequence
  sequence s_wr_hold;
    (!write_n_o && out_en_n_o && byte_data_lines_oe_o) [*3];
  endsequence
  property p_cs_min; $fell(chip_sel_n_o) |-> !chip_sel_n_o [*3]; endproperty
  a_cs_min: assert property (p_cs_min) else $error("select short");
  property p_cs_max; $fell(chip_sel_n_o) |-> ##[1:250] chip_sel_n_o; endproperty
  a_cs_max: assert property (p_cs_max) else $error("select long");
  property p_pre; $rose(chip_sel_n_o) |-> chip_sel_n_o [*2]; endproperty
  a_pre: assert property (p_pre) else $error("precharge short");
  property p_addr;
    !chip_sel_n_o && $past(!chip_sel_n_o) |-> $stable(mem_addr_o)
      && block_select_bits_o == mem_addr_o[12:10];
  endproperty
  a_addr: assert property (p_addr) else $error("address moved");
  property p_rd; s_rd |-> ##1 s_rd_hold ##3 rsp_valid_o;
  endproperty
  a_rd: assert property (p_rd) else $error("read walk");
  property p_wr; s_wr |-> ##1 s_wr_hold ##3 rsp_valid_o; endproperty
  a_wr: assert property (p_wr) else $error("write walk");
  property p_idle; chip_sel_n_o |-> write_n_o && out_en_n_o; endproperty
  a_idle: assert property (p_idle) else $error("strobe outside");
  property p_supply; !supply_ok_i [*3] |-> !req_ready_o; endproperty
  a_supply: assert property (p_supply) else $error("ready on low");
endmodule : nvbp_host_chk
bind nvbp_host nvbp_host_chk u_chk (.clk_sys_i, .rst_i, .req_valid_i,
  .req_write_i, .supply_ok_i, .req_ready_o, .rsp_valid_o, .mem_addr_o,
  .block_select_bits_o, .chip_sel_n_o, .write_n_o, .out_en_n_o,
  .byte_data_lines_oe_o);
`default_nettype wire

// ---- tb/tb_top.sv ----
`default_nettype none
// ----------------------------------------------------------------
// testbench for the bytewide host
// ----------------------------------------------------------------
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic req_valid_i = 1'b0;
  logic req_write_i = 1'b0;
  logic [12:0] req_addr_i = 13'h0000;
  logic [7:0] req_wdata_i = 8'h00;
  logic supply_ok_i = 1'b1;
  logic req_ready_o, rsp_valid_o, chip_sel_n_o, write_n_o, out_en_n_o;
  logic byte_data_lines_oe_o;
  logic [7:0] rsp_rdata_o, byte_data_lines_o, byte_data_lines_i, mem_q;
  logic [7:0] row_select_bits_o;
  logic [2:0] block_select_bits_o;
  logic [1:0] column_select_bits_o;
  logic [12:0] mem_addr_o;
  logic [8:0] q [$];
  logic [7:0] sh [int];
  logic [7:0] last_rd = 8'h00;
  logic [12:0] tbl [7] = '{13'h0000, 13'h00FF, 13'h0300, 13'h03FF,
    13'h0400, 13'h1C00, 13'h1FFF};
  int fails = 0;
  int n_checks = 0;
  always #20 clk_sys_i = ~clk_sys_i;
  nvbp_host u_dut (.clk_sys_i, .rst_i, .req_valid_i, .req_write_i,
    .req_addr_i, .req_wdata_i, .supply_ok_i, .req_ready_o, .rsp_valid_o,
    .rsp_rdata_o, .block_select_bits_o, .column_select_bits_o,
    .row_select_bits_o, .mem_addr_o_unused_guard_o(), .mem_addr_o,
    .chip_sel_n_o, .write_n_o, .out_en_n_o, .byte_data_lines_i,
    .byte_data_lines_o, .byte_data_lines_oe_o);
  nvbp_mem_model #(.ACC_NS(nvbp_pkg::ACCESS_NS)) u_mem (
    .cs_n_i(chip_sel_n_o), .we_n_i(write_n_o),
    .oe_n_i(out_en_n_o), .addr_i(mem_addr_o), .data_i(byte_data_lines_i),
    .data_o(mem_q));
  // wire level: the host wins while it drives, else the memory
  assign byte_data_lines_i = byte_data_lines_oe_o ? byte_data_lines_o : mem_q;
  task automatic bad(input string m);
    fails++;
    $display("MISMATCH %0t %s", $time, m);
  endtask : bad
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict
  task automatic cmp_byte(input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) bad("byte value");
  endtask : cmp_byte
  task automatic cmp_flag(input logic e, input logic g);
    n_checks++;
    if (g !== e) bad("flag");
  endtask : cmp_flag
  // one request, entered at a falling edge; the note is queued when taken
  task automatic do_req(input logic w, input logic [12:0] a,
      input logic [7:0] d);
    for (int n = 0; req_ready_o !== 1'b1; n++) begin
      if (n > 40) begin bad("ready timeout"); print_verdict(); end
      @(negedge clk_sys_i);
    end
    req_valid_i = 1'b1;
    req_write_i = w;
    req_addr_i = a;
    req_wdata_i = d;
    @(posedge clk_sys_i);
    if (w) sh[a] = d;
    q.push_back({!w, w ? last_rd : sh[a]});
    if (!w) last_rd = sh[a];
    @(negedge clk_sys_i);
    req_valid_i = 1'b0;
    cmp_byte(a[7:0], row_select_bits_o);
    cmp_byte({6'h00, a[9:8]}, {6'h00, column_select_bits_o});
    cmp_byte({5'h00, a[12:10]}, {5'h00, block_select_bits_o});
  endtask : do_req
  task automatic drain(input string t);
    for (int i = 0; i < 30 && q.size() != 0; i++) @(negedge clk_sys_i);
    if (q.size() != 0) begin bad("no answer"); print_verdict(); end
    $display("test %s done", t);
  endtask : drain
  // answer watcher: oldest note against each answer pulse
  always @(negedge clk_sys_i) begin
    if (!rst_i && rsp_valid_o === 1'b1) begin
      if (q.size() == 0) bad("stray answer");
      else if (q[0][8]) cmp_byte(q.pop_front()[7:0], rsp_rdata_o);
      else cmp_byte(q.pop_front()[7:0], rsp_rdata_o);
    end
  end
  initial begin
    logic [12:0] a;
    void'($urandom(32'h15C07518));
    repeat (8) @(negedge clk_sys_i);
    rst_i = 1'b0;
    // block, column and row edges, then random places; back to back
    for (int i = 0; i < 12; i++) begin
      a = (i < 7) ? tbl[i] : 13'($urandom);
      do_req(1'b1, a, 8'($urandom));
      do_req(1'b1, a, 8'($urandom));
      do_req(0, a, 8'h00);
    end
    drain("edges");
    // supply low: a pending write must not start
    supply_ok_i = 1'b0;
    repeat (3) @(negedge clk_sys_i);
    req_valid_i = 1'b1;
    req_write_i = 1'b1;
    for (int i = 0; i < 6; i++) begin
      @(negedge clk_sys_i);
      cmp_flag(1'b1, chip_sel_n_o);
    end
    req_valid_i = 1'b0;
    supply_ok_i = 1'b1;
    do_req(0, tbl[0], 8'h00);
    drain("supply");
    // reset in the middle of a write
    do_req(1'b1, 13'h1555, 8'hA5);
    rst_i = 1'b1;
    q.delete();
    last_rd = 8'h00;
    @(negedge clk_sys_i);
    cmp_flag(1'b1, chip_sel_n_o);
    cmp_flag(1'b0, byte_data_lines_oe_o);
    rst_i = 1'b0;
    do_req(0, tbl[6], 8'h00);
    drain("reset");
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
